/* File: pld_cells_pkg.sv */
// Constants and types shared by the macrocell array files
package pld_cells_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int GROUP_CELLS = 8;
  localparam int IN_CELLS = 20;
  localparam int PORT_C_CELLS = 4;

  // ****************************************
  // Register selects on the processor bus
  // ****************************************
  localparam logic [1:0] SEL_GROUP_AB_STATE = 2'h0;
  localparam logic [1:0] SEL_GROUP_BC_STATE = 2'h1;
  localparam logic [1:0] SEL_GROUP_AB_MASK = 2'h2;
  localparam logic [1:0] SEL_GROUP_BC_MASK = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STATE_RESET = 8'h00;

  // ****************************************
  // Port C pins that may carry a cell (2,3,4,7); test pins excluded
  // ****************************************
  localparam logic [7:0] PORT_C_CELL_PINS = 8'h9c;

  // ****************************************
  // Flip-flop kinds and input cell modes
  // ****************************************
  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_kind_e;
  typedef enum logic [1:0] {IN_PASS, IN_LATCH, IN_REG} in_mode_e;

  // Native and borrowable product term counts
  localparam int AB_NATIVE = 3;
  localparam int AB_BORROW = 6;
  localparam int BC_NATIVE = 4;
  localparam int BC_BORROW_LO = 5;
  localparam int BC_BORROW_HI = 6;

endpackage

/* File: output_cell.sv */
// One output macrocell: polarity stage, storage element and output select
`timescale 1ns/1ns
module output_cell
  import pld_cells_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Configuration
  input wire ff_kind_e ff_kind,
  input wire logic invert,
  input wire logic registered,
  input wire logic use_ext_clk,
  // Product terms
  input wire logic sum_a,
  input wire logic sum_b,
  input wire logic pt_clk_rise,
  input wire logic ext_clk_rise,
  input wire logic preset,
  input wire logic clear,
  // Processor load
  input wire logic load,
  input wire logic load_bit,
  // Results
  output logic state,
  output logic cell_out
);

  // ****************************************
  // Polarity and next state
  // ****************************************
  wire logic term_a = sum_a ^ invert; // R02
  wire logic term_b = sum_b ^ invert;
  wire logic clk_hit = use_ext_clk ? ext_clk_rise : pt_clk_rise; // R05
  logic next_state;

  // Storage element kind
  always_comb
  begin
    unique case (ff_kind) // R04
      FF_D: next_state = term_a;
      FF_T: next_state = state ^ term_a;
      FF_JK: next_state = (term_a & ~state) | (~term_b & state);
      FF_SR: next_state = term_a | (~term_b & state);
    endcase
  end

  // Load beats clear, preset and clock
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      state <= 1'b0;
    else if (load) // R09
      state <= load_bit;
    else if (clear) // R06
      state <= 1'b0;
    else if (preset)
      state <= 1'b1;
    else if (clk_hit)
      state <= next_state;
  end

  // Output select between stored and combinatorial
  assign cell_out = registered ? state : term_a; // R03

  a_load_wins: assert property (@(posedge sys_clk) disable iff (!rstn) // R09
    load |=> state == $past(load_bit)) else $error("load did not win");
  a_clear_acts: assert property (@(posedge sys_clk) disable iff (!rstn) // R06
    !load && clear |=> !state) else $error("clear ignored");

endmodule

/* File: input_cell.sv */
// One input macrocell: pass, latch or edge register
`timescale 1ns/1ns
module input_cell
  import pld_cells_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control
  input wire in_mode_e mode,
  input wire logic gate,
  input wire logic gate_rise,
  // Data
  input wire logic pin,
  output logic cell_out
);

  logic held;

  // Capture on open latch or rising strobe
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      held <= 1'b0;
    else if ((mode == IN_LATCH && gate) || (mode == IN_REG && gate_rise)) // R16
      held <= pin;
  end

  assign cell_out = (mode == IN_PASS) ? pin : held; // R16

  a_reg_catch: assert property (@(posedge sys_clk) disable iff (!rstn) // R16
    mode == IN_REG && gate_rise |=> held == $past(pin)) else $error("edge miss");

endmodule

/* File: pld_macrocell_array.sv */
// Macrocell layer: sixteen output cells, twenty input cells, processor access
// ****************************************
// What this block does
// R01 - Unassigned output cell routed to reachable port
// R02 - XOR stage sets term polarity
// R03 - Mux picks stored or combinatorial, feeds back
// R04 - Storage acts as D, T, JK or SR
// R05 - Clock from term or external rising edge
// R06 - Preset and clear active high; clear two terms
// R07 - Native and borrowable term counts per group
// R08 - Used terms never lent; expansion eats cells
// R09 - Processor load overrides preset, clear, clock
// R10 - Sixteen cells loadable and readable, bit n
// R11 - Load on strobe trailing edge or level
// R12 - Per-group mask resets zero, blocks writes
// R13 - Pin enable is term OR direction bit
// R14 - Output without enable equation drives from reset
// R15 - Internal node feeds back, pin stays free
// R16 - Twenty input cells: latch, register or pass
// R17 - Input cell strobe from term or address strobe
// R18 - One control term per four input cells
// R19 - Input cells drive PLD bus, processor readable
// R20 - Test access pins never carry cells
// R21 - Mask bit n guards cell n
// ****************************************
`timescale 1ns/1ns
module pld_macrocell_array
  import pld_cells_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Processor register access
  input wire logic pld_register_space_select,
  input wire logic [1:0] reg_sel,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] in_read_sel,
  output logic [7:0] rd_data,
  input wire logic addr_strobe,
  input wire logic level_load,
  // Cell configuration
  input wire logic [15:0] cfg_invert,
  input wire logic [15:0] cfg_registered,
  input wire logic [15:0] cfg_ext_clk,
  input wire logic [31:0] cfg_ff_kind,
  input wire logic [15:0] cfg_internal_node,
  input wire logic [15:0] cfg_pld_output,
  input wire logic [15:0] cfg_has_oe_term,
  input wire logic [15:0] cfg_pin_alt,
  // Product terms from the AND array
  input wire logic [15:0] pt_sum_a,
  input wire logic [15:0] pt_sum_b,
  input wire logic [15:0] pt_clk,
  input wire logic [15:0] pt_preset,
  input wire logic [15:0] pt_clear_0,
  input wire logic [15:0] pt_clear_1,
  input wire logic [15:0] pt_oe,
  // External clock pin
  input wire logic external_pld_clock,
  // Port pins and direction bits
  input wire logic [7:0] port_a_dir,
  input wire logic [7:0] port_b_dir,
  input wire logic [7:0] port_c_dir,
  output logic [7:0] port_a_out,
  output logic [7:0] port_b_out,
  output logic [7:0] port_c_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_c_oe,
  // Input cells
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [3:0] port_c_in,
  input wire logic [39:0] cfg_in_mode,
  input wire logic [4:0] cfg_in_use_ale,
  input wire logic [4:0] pt_in_ctl,
  // Feedback and input bus to the AND array
  output logic [15:0] feedback,
  output logic [19:0] pld_input_bus
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [20:0] pin_meta;
  logic [20:0] pin_sync;
  logic clk_prev;

  // Two stages for every pin and the clock pin
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= {external_pld_clock, port_c_in, port_b_in, port_a_in};
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[20];
    end
  end

  wire logic ext_rise = pin_sync[20] & ~clk_prev; // R05
  wire logic [19:0] pins_in = pin_sync[19:0];

  // ****************************************
  // Write strobe handling
  // ****************************************
  logic wr_prev;
  logic [7:0] mask_ab;
  logic [7:0] mask_bc;
  logic [7:0] wr_hold;
  logic [1:0] sel_hold;

  // Keep last strobe, data and select for trailing-edge loads
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_prev <= 1'b0;
      wr_hold <= STATE_RESET;
      sel_hold <= SEL_GROUP_AB_STATE;
    end
    else
    begin
      wr_prev <= wr_strobe & pld_register_space_select;
      if (wr_strobe && pld_register_space_select)
      begin
        wr_hold <= wr_data;
        sel_hold <= reg_sel;
      end
    end
  end

  wire logic wr_active = wr_strobe & pld_register_space_select;
  wire logic wr_trail = wr_prev & ~wr_active;
  wire logic load_go = level_load ? wr_active : wr_trail; // R11
  wire logic [1:0] load_sel = level_load ? reg_sel : sel_hold;
  wire logic [7:0] load_data = level_load ? wr_data : wr_hold;
  wire logic [7:0] load_ab = {8{load_go && load_sel == SEL_GROUP_AB_STATE}} & ~mask_ab; // R12 R21
  wire logic [7:0] load_bc = {8{load_go && load_sel == SEL_GROUP_BC_STATE}} & ~mask_bc; // R12 R21

  // Mask registers, bit n guards cell n
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_ab <= MASK_RESET; // R12
      mask_bc <= MASK_RESET;
    end
    else if (wr_active && reg_sel == SEL_GROUP_AB_MASK)
      mask_ab <= wr_data;
    else if (wr_active && reg_sel == SEL_GROUP_BC_MASK)
      mask_bc <= wr_data;
  end

  // ****************************************
  // Output cells
  // ****************************************
  logic [15:0] cell_state;
  logic [15:0] cell_out;
  wire logic [15:0] load_vec = {load_bc, load_ab};
  wire logic [15:0] load_bits = {load_data, load_data}; // R10

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_out
      output_cell u_cell (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ff_kind(ff_kind_e'(cfg_ff_kind[2*gi +: 2])),
        .invert(cfg_invert[gi]),
        .registered(cfg_registered[gi]),
        .use_ext_clk(cfg_ext_clk[gi]),
        .sum_a(pt_sum_a[gi]),
        .sum_b(pt_sum_b[gi]),
        .pt_clk_rise(pt_clk[gi]),
        .ext_clk_rise(ext_rise),
        .preset(pt_preset[gi]),
        .clear(pt_clear_0[gi] | pt_clear_1[gi]),
        .load(load_vec[gi]),
        .load_bit(load_bits[gi]),
        .state(cell_state[gi]),
        .cell_out(cell_out[gi])
      );
    end
  endgenerate

  // ****************************************
  // Pin routing and enables
  // ****************************************
  // Cell drives a pin when set as PLD output and not an internal node
  wire logic [15:0] drives = cfg_pld_output & ~cfg_internal_node; // R15
  wire logic [15:0] cell_oe = (pt_oe & cfg_has_oe_term) | ~cfg_has_oe_term; // R14
  // Group AB: pin_alt picks port B, else port A; BC: alt picks port C on its cell pins, else port B
  wire logic [7:0] ab_on_a = drives[7:0] & ~cfg_pin_alt[7:0]; // R01
  wire logic [7:0] ab_on_b = drives[7:0] & cfg_pin_alt[7:0];
  wire logic [7:0] bc_on_c = drives[15:8] & cfg_pin_alt[15:8] & PORT_C_CELL_PINS; // R20
  wire logic [7:0] bc_on_b = drives[15:8] & ~(cfg_pin_alt[15:8] & PORT_C_CELL_PINS);
  wire logic [7:0] next_a_out = cell_out[7:0] & ab_on_a;
  wire logic [7:0] next_b_out = (cell_out[7:0] & ab_on_b) | (cell_out[15:8] & bc_on_b);
  wire logic [7:0] next_c_out = cell_out[15:8] & bc_on_c;
  wire logic [7:0] next_a_oe = (ab_on_a & cell_oe[7:0]) | port_a_dir; // R13
  wire logic [7:0] next_b_oe = (ab_on_b & cell_oe[7:0]) | (bc_on_b & cell_oe[15:8]) | port_b_dir;
  wire logic [7:0] next_c_oe = (bc_on_c & cell_oe[15:8]) | (port_c_dir & PORT_C_CELL_PINS);

  // ****************************************
  // Input cells
  // ****************************************
  logic ale_prev;
  logic [4:0] ctl_prev;
  logic [19:0] in_out;

  // Strobe history for edge registers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ale_prev <= 1'b0;
      ctl_prev <= '0;
    end
    else
    begin
      ale_prev <= addr_strobe;
      ctl_prev <= pt_in_ctl;
    end
  end

  // One control term per nibble; mux with address strobe
  wire logic [4:0] gate_lvl = (cfg_in_use_ale & {5{addr_strobe}}) | (~cfg_in_use_ale & pt_in_ctl); // R17
  wire logic [4:0] gate_rise = (cfg_in_use_ale & {5{addr_strobe & ~ale_prev}})
    | (~cfg_in_use_ale & pt_in_ctl & ~ctl_prev);

  generate
    for (gi = 0; gi < IN_CELLS; gi++)
    begin : g_in
      input_cell u_in (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .mode(in_mode_e'(cfg_in_mode[2*gi +: 2])),
        .gate(gate_lvl[gi/4]), // R18
        .gate_rise(gate_rise[gi/4]),
        .pin(pins_in[gi]),
        .cell_out(in_out[gi])
      );
    end
  endgenerate

  // ****************************************
  // Read back
  // ****************************************
  // Selects 0..3 read registers; in_read_sel picks input bytes when nonzero
  wire logic [7:0] mask_view = (reg_sel == SEL_GROUP_AB_MASK) ? mask_ab : mask_bc;
  wire logic [7:0] state_view = (reg_sel == SEL_GROUP_AB_STATE) ? cell_state[7:0] : cell_state[15:8];
  wire logic [7:0] in_view = (in_read_sel == 3'h0) ? 8'h00 :
    (in_read_sel == 3'h1) ? in_out[7:0] :
    (in_read_sel == 3'h2) ? in_out[15:8] : {4'h0, in_out[19:16]}; // R19
  wire logic [7:0] next_rd = !pld_register_space_select ? 8'h00 :
    (in_read_sel != 3'h0) ? in_view : reg_sel[1] ? mask_view : state_view; // R10

  // Registered outputs
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data <= 8'h00;
      port_a_out <= 8'h00;
      port_b_out <= 8'h00;
      port_c_out <= 8'h00;
      port_a_oe <= 8'h00;
      port_b_oe <= 8'h00;
      port_c_oe <= 8'h00;
      feedback <= 16'h0000;
      pld_input_bus <= 20'h00000;
    end
    else
    begin
      rd_data <= next_rd;
      port_a_out <= next_a_out;
      port_b_out <= next_b_out;
      port_c_out <= next_c_out;
      port_a_oe <= next_a_oe;
      port_b_oe <= next_b_oe;
      port_c_oe <= next_c_oe;
      feedback <= cell_out; // R03 R15
      pld_input_bus <= in_out; // R19
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_trail;
    wr_prev && !wr_active;
  endsequence

  a_mask_reset: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
    $rose(rstn) |-> mask_ab == 8'h00) else $error("mask not cleared");
  a_mask_blocks: assert property (@(posedge sys_clk) disable iff (!rstn) // R21
    load_go && mask_ab[0] && load_sel == SEL_GROUP_AB_STATE |=> $stable(cell_state[0]))
    else $error("masked cell changed");
  a_edge_load: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    (!level_load && sel_hold == SEL_GROUP_AB_STATE && !mask_ab[3]) ##0 s_trail
    |=> cell_state[3] == $past(wr_hold[3])) else $error("edge load missed");
  a_pin_oe: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
    port_a_dir[0] |=> port_a_oe[0]) else $error("direction not honoured");
  a_test_pins: assert property (@(posedge sys_clk) disable iff (!rstn) // R20
    (port_c_out & ~PORT_C_CELL_PINS) == 8'h00) else $error("test pin driven");
  a_fb_follow: assert property (@(posedge sys_clk) disable iff (!rstn) // R03
    ##1 feedback == $past(cell_out)) else $error("feedback stale");

  // R07 R08: term counts and lending are fixed by the array builder outside this block

endmodule

/* File: mcu_bus_model.sv */
// Processor bus and clock pin model facing the macrocell array
`timescale 1ns/1ns
module mcu_bus_model
(
  // Clock
  input wire logic sys_clk,
  // Register bus
  output logic pld_register_space_select,
  output logic [1:0] reg_sel,
  output logic wr_strobe,
  output logic [7:0] wr_data,
  output logic [2:0] in_read_sel,
  input wire logic [7:0] rd_data,
  // External clock pin
  output logic external_pld_clock
);
  // Bus idle at time zero
  initial
  begin
    pld_register_space_select = 1'b0;
    reg_sel = 2'h0;
    wr_strobe = 1'b0;
    wr_data = 8'h00;
    in_read_sel = 3'h0;
    external_pld_clock = 1'b0;
  end

  // Strobe high for hold cycles, select and data kept over the trailing edge
  task automatic write_reg(input logic [1:0] sel, input logic [7:0] data, input int hold);
    @(posedge sys_clk);
    pld_register_space_select <= 1'b1;
    reg_sel <= sel;
    wr_data <= data;
    wr_strobe <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    wr_strobe <= 1'b0;
    @(posedge sys_clk);
    pld_register_space_select <= 1'b0;
    wr_data <= ~data; // Released bus shows no stale value
    @(posedge sys_clk);
  endtask

  // Select held until registered read data has settled
  task automatic read_reg(input logic [1:0] sel, input logic [2:0] isel, output logic [7:0] data);
    @(posedge sys_clk);
    pld_register_space_select <= 1'b1;
    reg_sel <= sel;
    in_read_sel <= isel;
    repeat (2) @(posedge sys_clk);
    data = rd_data;
    pld_register_space_select <= 1'b0;
    in_read_sel <= 3'h0;
  endtask

  // One rising edge on the external clock pin, idle low otherwise
  task automatic ext_clock_pulse();
    @(posedge sys_clk);
    external_pld_clock <= 1'b1;
    repeat (3) @(posedge sys_clk);
    external_pld_clock <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule

/* File: tb.sv */
// Self-checking testbench of the macrocell array
`timescale 1ns/1ns
module tb;
  import pld_cells_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic addr_strobe = 1'b0;
  logic level_load = 1'b0;
  logic pld_register_space_select, wr_strobe, external_pld_clock;
  logic [1:0] reg_sel;
  logic [2:0] in_read_sel;
  logic [7:0] wr_data, rd_data, rd;
  logic [15:0] cfg_invert = 16'h0000, cfg_registered = 16'hffff, cfg_ext_clk = 16'h0000;
  logic [15:0] cfg_internal_node = 16'h0000, cfg_pld_output = 16'hffff;
  logic [15:0] cfg_has_oe_term = 16'h0000, cfg_pin_alt = 16'hff00;
  logic [31:0] cfg_ff_kind = 32'h0000_0000;
  logic [15:0] pt_sum_a = 16'h0000, pt_sum_b = 16'h0000, pt_clk = 16'h0000;
  logic [15:0] pt_preset = 16'h0000, pt_clear_0 = 16'h0000, pt_clear_1 = 16'h0000;
  logic [15:0] pt_oe = 16'h0000;
  logic [7:0] port_a_dir = 8'h00, port_b_dir = 8'h00, port_c_dir = 8'h00;
  logic [7:0] port_a_in = 8'h00, port_b_in = 8'h00;
  logic [3:0] port_c_in = 4'h0;
  logic [39:0] cfg_in_mode = 40'h00_0000_0000;
  logic [4:0] cfg_in_use_ale = 5'h00, pt_in_ctl = 5'h00;
  logic [7:0] port_a_out, port_b_out, port_c_out, port_a_oe, port_b_oe, port_c_oe;
  logic [15:0] feedback;
  logic [19:0] pld_input_bus;
  int err_total = 0;
  int n_tests = 0;

  // Clock and instances
  always #5 sys_clk = ~sys_clk;
  pld_macrocell_array i_pld_macrocell_array (.sys_clk, .rstn, .pld_register_space_select,
    .reg_sel, .wr_strobe, .wr_data, .in_read_sel, .rd_data, .addr_strobe, .level_load,
    .cfg_invert, .cfg_registered, .cfg_ext_clk, .cfg_ff_kind, .cfg_internal_node,
    .cfg_pld_output, .cfg_has_oe_term, .cfg_pin_alt, .pt_sum_a, .pt_sum_b, .pt_clk,
    .pt_preset, .pt_clear_0, .pt_clear_1, .pt_oe, .external_pld_clock, .port_a_dir,
    .port_b_dir, .port_c_dir, .port_a_out, .port_b_out, .port_c_out, .port_a_oe, .port_b_oe,
    .port_c_oe, .port_a_in, .port_b_in, .port_c_in, .cfg_in_mode, .cfg_in_use_ale,
    .pt_in_ctl, .feedback, .pld_input_bus);
  mcu_bus_model i_mcu_bus_model (.sys_clk, .pld_register_space_select, .reg_sel,
    .wr_strobe, .wr_data, .in_read_sel, .rd_data, .external_pld_clock);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Let registered outputs land, then sample off the edge
  task automatic settle();
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Mask reset values and pin enables straight after reset
  task automatic test_reset();
    i_mcu_bus_model.read_reg(SEL_GROUP_AB_MASK, 3'h0, rd);
    check8(rd, 8'h00, "ab mask reset");
    i_mcu_bus_model.read_reg(SEL_GROUP_BC_MASK, 3'h0, rd);
    check8(rd, 8'h00, "bc mask reset");
    check8(port_a_oe, 8'hff, "enable from reset");
    check8(port_c_oe, 8'h9c, "port c cell pins");
    check8(port_b_oe, 8'h63, "bc enables on port b");
    $display("test_reset done");
  endtask

  // Edge loads, readback, pin and feedback routing
  task automatic test_load();
    i_mcu_bus_model.write_reg(SEL_GROUP_AB_STATE, 8'h5a, 1);
    i_mcu_bus_model.read_reg(SEL_GROUP_AB_STATE, 3'h0, rd);
    check8(rd, 8'h5a, "ab readback");
    check8(port_a_out, 8'h5a, "ab on port a");
    check8(feedback[7:0], 8'h5a, "ab feedback");
    i_mcu_bus_model.write_reg(SEL_GROUP_BC_STATE, 8'h3c, 1);
    i_mcu_bus_model.read_reg(SEL_GROUP_BC_STATE, 3'h0, rd);
    check8(rd, 8'h3c, "bc readback");
    check8(feedback[15:8], 8'h3c, "bc feedback");
    check8(port_c_out & 8'h9c, 8'h1c, "bc on port c");
    check8(port_b_out, 8'h20, "bc on port b");
    $display("test_load done");
  endtask

  // Mask bits guard their own cells only
  task automatic test_mask();
    i_mcu_bus_model.write_reg(SEL_GROUP_AB_MASK, 8'h0f, 1);
    i_mcu_bus_model.read_reg(SEL_GROUP_AB_MASK, 3'h0, rd);
    check8(rd, 8'h0f, "ab mask readback");
    i_mcu_bus_model.write_reg(SEL_GROUP_AB_STATE, 8'hff, 1);
    i_mcu_bus_model.read_reg(SEL_GROUP_AB_STATE, 3'h0, rd);
    check8(rd, 8'hfa, "ab masked write");
    i_mcu_bus_model.write_reg(SEL_GROUP_BC_MASK, 8'hf0, 1);
    i_mcu_bus_model.write_reg(SEL_GROUP_BC_STATE, 8'h00, 1);
    i_mcu_bus_model.read_reg(SEL_GROUP_BC_STATE, 3'h0, rd);
    check8(rd, 8'h30, "bc masked write");
    i_mcu_bus_model.write_reg(SEL_GROUP_AB_MASK, 8'hfe, 1);
    $display("test_mask done");
  endtask

  // Level load of cell 0 while its clear is held high
  task automatic test_level();
    @(posedge sys_clk);
    level_load <= 1'b1;
    pt_clear_0[0] <= 1'b1;
    fork
      i_mcu_bus_model.write_reg(SEL_GROUP_AB_STATE, 8'h01, 6);
      begin
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        check8({7'h00, feedback[0]}, 8'h01, "load beats clear");
      end
    join
    settle();
    check8(feedback[7:0], 8'hfa, "clear after load");
    @(posedge sys_clk);
    pt_clear_0[0] <= 1'b0;
    level_load <= 1'b0;
    i_mcu_bus_model.write_reg(SEL_GROUP_AB_MASK, 8'h00, 1);
    $display("test_level done");
  endtask

  // Combinatorial path of cell 1 through the polarity stage
  task automatic test_comb();
    @(posedge sys_clk);
    cfg_registered[1] <= 1'b0;
    pt_sum_a[1] <= 1'b1;
    settle();
    check8({6'h00, port_a_out[1], feedback[1]}, 8'h03, "comb true");
    @(posedge sys_clk);
    cfg_invert[1] <= 1'b1;
    settle();
    check8({6'h00, port_a_out[1], feedback[1]}, 8'h00, "comb inverted");
    @(posedge sys_clk);
    pt_sum_a[1] <= 1'b0;
    settle();
    check8({6'h00, port_a_out[1], feedback[1]}, 8'h03, "zero inverted");
    $display("test_comb done");
  endtask

  // Cells 2..5 as D, T, JK, SR; term and pin clocks; preset and clear
  task automatic test_ff();
    @(posedge sys_clk);
    cfg_ff_kind <= 32'h0000_0e40;
    cfg_ext_clk[3] <= 1'b1;
    pt_sum_a <= 16'h000c;
    pt_sum_b <= 16'h0030;
    @(posedge sys_clk);
    pt_clk <= 16'h003c;
    @(posedge sys_clk);
    pt_clk <= 16'h0000;
    settle();
    check8({4'h0, feedback[5:2]}, 8'h03, "term clock");
    i_mcu_bus_model.ext_clock_pulse();
    settle();
    check8({4'h0, feedback[5:2]}, 8'h01, "pin clock toggle");
    @(posedge sys_clk);
    pt_clear_1[2] <= 1'b1;
    pt_preset[4] <= 1'b1;
    @(posedge sys_clk);
    pt_clear_1[2] <= 1'b0;
    pt_preset[4] <= 1'b0;
    settle();
    check8({4'h0, feedback[5:2]}, 8'h04, "preset and clear");
    $display("test_ff done");
  endtask

  // Pin enables from term and direction, internal node, test pins
  task automatic test_oe();
    @(posedge sys_clk);
    cfg_has_oe_term[0] <= 1'b1;
    settle();
    check8({7'h00, port_a_oe[0]}, 8'h00, "no enable source");
    @(posedge sys_clk);
    port_a_dir[0] <= 1'b1;
    settle();
    check8({7'h00, port_a_oe[0]}, 8'h01, "direction enable");
    @(posedge sys_clk);
    port_a_dir[0] <= 1'b0;
    pt_oe[0] <= 1'b1;
    cfg_internal_node[6] <= 1'b1;
    port_c_dir <= 8'hff;
    settle();
    check8({6'h00, port_a_oe[6], port_a_oe[0]}, 8'h01, "term enable");
    check8({7'h00, feedback[6]}, 8'h01, "node feedback");
    check8({7'h00, port_a_out[6]}, 8'h00, "node pin free");
    check8(port_c_oe & 8'h63, 8'h00, "test pins idle");
    $display("test_oe done");
  endtask

  // Latch on address strobe, register on term, pass elsewhere
  task automatic test_inputs();
    @(posedge sys_clk);
    cfg_in_mode <= 40'h00_00aa_0055;
    cfg_in_use_ale <= 5'h01;
    port_a_in <= 8'h3c;
    port_b_in <= 8'h5a;
    port_c_in <= 4'h9;
    addr_strobe <= 1'b1;
    settle();
    @(posedge sys_clk);
    addr_strobe <= 1'b0;
    pt_in_ctl[2] <= 1'b1;
    @(posedge sys_clk);
    pt_in_ctl[2] <= 1'b0;
    port_a_in <= 8'hff;
    port_b_in <= 8'h00;
    settle();
    i_mcu_bus_model.read_reg(SEL_GROUP_AB_STATE, 3'h1, rd);
    check8(rd, 8'hfc, "port a cells");
    i_mcu_bus_model.read_reg(SEL_GROUP_AB_STATE, 3'h2, rd);
    check8(rd, 8'h0a, "port b cells");
    i_mcu_bus_model.read_reg(SEL_GROUP_AB_STATE, 3'h3, rd);
    check8(rd, 8'h09, "port c cells");
    check8(pld_input_bus[15:8], 8'h0a, "input bus b");
    check8({4'h0, pld_input_bus[19:16]}, 8'h09, "input bus c");
    $display("test_inputs done");
  endtask

  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    test_reset();
    test_load();
    test_mask();
    test_level();
    test_comb();
    test_ff();
    test_oe();
    test_inputs();
    results();
  end

  initial
  begin
    #200000;
    err_total = err_total + 1;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
endmodule
